// *** src/gpc_pin_pad.sv ***
// One configurable pin: decodes its nibble into pad drive signals.
// Assumes the nibble and function signal are on core_clk.
`timescale 1ns/1ns
`default_nettype none
module gpc_pin_pad
	import gpc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] nibble,
	input wire logic func_out,
	input wire logic pad_in_sync,
	output logic pad_out,
	output logic pad_oe,
	output logic gp_in_level
);
	gpc_mode_t mode;
	assign mode = gpc_mode_t'({nibble[GPC_FLD_DIRECTION],
		nibble[GPC_FLD_ENABLE]});

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
			gp_in_level <= 1'b0;
		end else begin
			case (mode)
				GPC_MODE_FUNC_OUT: begin
					pad_out <= func_out;
					pad_oe <= 1'b1;
				end
				GPC_MODE_GP_OUT: begin
					// Remote control absent, local level always drives
					pad_out <= nibble[GPC_FLD_LEVEL];
					pad_oe <= 1'b1;
				end
				default: begin
					pad_out <= 1'b0;
					pad_oe <= 1'b0;
				end
			endcase
			gp_in_level <= (mode == GPC_MODE_GP_IN) ? pad_in_sync : 1'b0;
		end
	end
endmodule : gpc_pin_pad
`default_nettype wire

// *** src/gpc_pkg.sv ***
// Package for the pin setup and video path control register slice.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package gpc_pkg;
	// Printed offsets are not all multiples of four: they are word indices
	localparam logic [7:0] GPC_IDX_PINS_FIVE_SIX = 8'h20;
	localparam logic [7:0] GPC_IDX_PINS_SEVEN_EIGHT = 8'h21;
	localparam logic [7:0] GPC_IDX_VIDEO_PATH = 8'h22;
	localparam int GPC_ADDR_W = 12;
	localparam logic [GPC_ADDR_W-1:0] GPC_ADDR_PINS_FIVE_SIX =
		{2'h0, GPC_IDX_PINS_FIVE_SIX, 2'h0};
	localparam logic [GPC_ADDR_W-1:0] GPC_ADDR_PINS_SEVEN_EIGHT =
		{2'h0, GPC_IDX_PINS_SEVEN_EIGHT, 2'h0};
	localparam logic [GPC_ADDR_W-1:0] GPC_ADDR_VIDEO_PATH =
		{2'h0, GPC_IDX_VIDEO_PATH, 2'h0};
	localparam logic [7:0] GPC_RST_PINS = 8'h00;
	localparam logic [7:0] GPC_RST_VIDEO_PATH = 8'h00;
	// Field positions within a four-bit pin nibble
	localparam int GPC_FLD_ENABLE = 0;
	localparam int GPC_FLD_DIRECTION = 1;
	localparam int GPC_FLD_LEVEL = 3;
	localparam int GPC_NIBBLE_W = 4;
	// Field positions of the video path control register
	localparam int GPC_FLD_HOLD_LOCAL = 7;
	localparam int GPC_FLD_PASS_THROUGH = 6;
	localparam int GPC_FLD_DATA_ENABLE_POLARITY = 5;
	localparam int GPC_NUM_PINS = 4;
	// Pad modes, {direction, enable}
	typedef enum logic [1:0] {
		GPC_MODE_FUNC_OUT = 2'h0,
		GPC_MODE_GP_OUT = 2'h1,
		GPC_MODE_TRISTATE = 2'h2,
		GPC_MODE_GP_IN = 2'h3
	} gpc_mode_t;
endpackage : gpc_pkg

// *** src/gpc_top.sv ***
// APB register slice for pins five to eight and the video path control.
// Assumes forward-channel loads and video arrive on core_clk; pads are raw.
`timescale 1ns/1ns
`default_nettype none
module gpc_top
	import gpc_pkg::*;
#(
	parameter int COLOUR_W = 24
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [GPC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fc_load,
	input wire logic [7:0] fc_path_value,
	input wire logic [GPC_NUM_PINS-1:0] func_out,
	input wire logic [GPC_NUM_PINS-1:0] pad_in,
	output logic [GPC_NUM_PINS-1:0] pad_out,
	output logic [GPC_NUM_PINS-1:0] pad_oe,
	output logic [GPC_NUM_PINS-1:0] gp_in_level,
	input wire logic data_enable,
	input wire logic [COLOUR_W-1:0] colour_in,
	input wire logic audio_packet_in,
	output logic [COLOUR_W-1:0] colour_out,
	output logic colour_valid,
	output logic audio_packet_out,
	output logic protect_allowed
);
	logic [7:0] pins_five_six_setup_q;
	logic [7:0] pins_seven_eight_setup_q;
	logic [7:0] video_path_control_q;
	logic [GPC_NUM_PINS-1:0] pad_meta_q;
	logic [GPC_NUM_PINS-1:0] pad_sync_q;
	logic access;
	logic wr_en;
	logic hit;
	logic [7:0] rd_mux;
	logic hold_local_path_settings;
	logic colour_pass_through;
	logic data_enable_polarity;
	logic de_active;
	logic [15:0] pin_nibbles;

	assign access = psel & penable;
	assign wr_en = access & pwrite & pstrb[0];
	assign hit = (paddr == GPC_ADDR_PINS_FIVE_SIX) |
		(paddr == GPC_ADDR_PINS_SEVEN_EIGHT) |
		(paddr == GPC_ADDR_VIDEO_PATH);
	assign hold_local_path_settings = video_path_control_q[GPC_FLD_HOLD_LOCAL];
	assign colour_pass_through = video_path_control_q[GPC_FLD_PASS_THROUGH];
	assign data_enable_polarity = video_path_control_q[GPC_FLD_DATA_ENABLE_POLARITY];

	// Pin setup registers, all bits writable including reserved ones
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_five_six_setup_q <= GPC_RST_PINS;
			pins_seven_eight_setup_q <= GPC_RST_PINS;
		end else if (wr_en) begin
			if (paddr == GPC_ADDR_PINS_FIVE_SIX) begin
				pins_five_six_setup_q <= pwdata[7:0];
			end
			if (paddr == GPC_ADDR_PINS_SEVEN_EIGHT) begin
				pins_seven_eight_setup_q <= pwdata[7:0];
			end
		end
	end

	// Software write wins over a forward-channel load in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			video_path_control_q <= GPC_RST_VIDEO_PATH;
		end else if (wr_en && paddr == GPC_ADDR_VIDEO_PATH) begin
			video_path_control_q <= pwdata[7:0];
		end else if (fc_load && !hold_local_path_settings) begin
			// Remote copies all but the hold bit, which stays local
			video_path_control_q[6:0] <= fc_path_value[6:0];
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		case (paddr)
			GPC_ADDR_PINS_FIVE_SIX: rd_mux = pins_five_six_setup_q;
			GPC_ADDR_PINS_SEVEN_EIGHT: rd_mux = pins_seven_eight_setup_q;
			GPC_ADDR_VIDEO_PATH: rd_mux = video_path_control_q;
			default: rd_mux = 8'h00;
		endcase
	end

	// Zero-wait APB: ready during every access phase
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			prdata <= (psel && !penable && !pwrite) ?
				{24'h000000, rd_mux} : 32'h00000000;
		end
	end

	// Pad inputs pass two flip-flops before use
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_meta_q <= '0;
			pad_sync_q <= '0;
		end else begin
			pad_meta_q <= pad_in;
			pad_sync_q <= pad_meta_q;
		end
	end

	assign pin_nibbles = {pins_seven_eight_setup_q, pins_five_six_setup_q};

	genvar gi;
	generate
		for (gi = 0; gi < GPC_NUM_PINS; gi++) begin : g_pin
			gpc_pin_pad u_pad (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.nibble(pin_nibbles[gi*GPC_NIBBLE_W +: GPC_NIBBLE_W]),
				.func_out(func_out[gi]),
				.pad_in_sync(pad_sync_q[gi]),
				.pad_out(pad_out[gi]),
				.pad_oe(pad_oe[gi]),
				.gp_in_level(gp_in_level[gi])
			);
		end
	endgenerate

	assign de_active = data_enable ^ data_enable_polarity;

	// Video path gating
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			colour_out <= '0;
			colour_valid <= 1'b0;
			audio_packet_out <= 1'b0;
			protect_allowed <= 1'b0;
		end else begin
			colour_valid <= colour_pass_through | de_active;
			colour_out <= (colour_pass_through || de_active) ?
				colour_in : '0;
			audio_packet_out <= audio_packet_in & ~colour_pass_through;
			protect_allowed <= ~colour_pass_through;
		end
	end

	property p_pass_valid;
		@(posedge core_clk) disable iff (!rst_n)
		colour_pass_through |=> colour_valid;
	endproperty
	a_pass_valid: assert property (p_pass_valid)
		else $error("pass-through did not force colour valid");

	property p_audio_block;
		@(posedge core_clk) disable iff (!rst_n)
		colour_pass_through |=> !audio_packet_out && !protect_allowed;
	endproperty
	a_audio_block: assert property (p_audio_block)
		else $error("audio or protection not blocked in pass-through");

	property p_data_enable_polarity;
		@(posedge core_clk) disable iff (!rst_n)
		!colour_pass_through && data_enable_polarity && !data_enable
		|=> colour_valid;
	endproperty
	a_data_enable_polarity: assert property (p_data_enable_polarity)
		else $error("inverted data enable not honoured");

	property p_de_normal;
		@(posedge core_clk) disable iff (!rst_n)
		!colour_pass_through && !data_enable_polarity && !data_enable
		|=> !colour_valid;
	endproperty
	a_de_normal: assert property (p_de_normal)
		else $error("idle data enable passed colour");

	property p_hold_local;
		@(posedge core_clk) disable iff (!rst_n)
		hold_local_path_settings && !(wr_en && paddr == GPC_ADDR_VIDEO_PATH)
		|=> $stable(video_path_control_q);
	endproperty
	a_hold_local: assert property (p_hold_local)
		else $error("held path settings changed by forward channel");

	property p_fc_load;
		@(posedge core_clk) disable iff (!rst_n)
		fc_load && !hold_local_path_settings &&
		!(wr_en && paddr == GPC_ADDR_VIDEO_PATH)
		|=> video_path_control_q[6:5] == $past(fc_path_value[6:5]);
	endproperty
	a_fc_load: assert property (p_fc_load)
		else $error("forward channel load not applied");

	property p_write_five_six;
		@(posedge core_clk) disable iff (!rst_n)
		wr_en && paddr == GPC_ADDR_PINS_FIVE_SIX
		|=> pins_five_six_setup_q == $past(pwdata[7:0]);
	endproperty
	a_write_five_six: assert property (p_write_five_six)
		else $error("pin five/six setup write lost");

	property p_gp_out;
		@(posedge core_clk) disable iff (!rst_n)
		pins_five_six_setup_q[1:0] == 2'h1 && $stable(pins_five_six_setup_q)
		|=> pad_oe[0] && pad_out[0] == $past(pins_five_six_setup_q[GPC_FLD_LEVEL]);
	endproperty
	a_gp_out: assert property (p_gp_out)
		else $error("pin five does not drive local level");

	property p_tristate;
		@(posedge core_clk) disable iff (!rst_n)
		pins_seven_eight_setup_q[5:4] == 2'h2 |=> !pad_oe[3];
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("pin eight driven while tri-stated");

	property p_write_seven_eight;
		@(posedge core_clk) disable iff (!rst_n)
		wr_en && paddr == GPC_ADDR_PINS_SEVEN_EIGHT
		|=> pins_seven_eight_setup_q == $past(pwdata[7:0]);
	endproperty
	a_write_seven_eight: assert property (p_write_seven_eight)
		else $error("pin seven/eight setup write lost");

	property p_write_video;
		@(posedge core_clk) disable iff (!rst_n)
		wr_en && paddr == GPC_ADDR_VIDEO_PATH
		|=> video_path_control_q == $past(pwdata[7:0]);
	endproperty
	a_write_video: assert property (p_write_video)
		else $error("local video path write lost");

	property p_hold_bit_local;
		@(posedge core_clk) disable iff (!rst_n)
		!(wr_en && paddr == GPC_ADDR_VIDEO_PATH)
		|=> $stable(hold_local_path_settings);
	endproperty
	a_hold_bit_local: assert property (p_hold_bit_local)
		else $error("hold bit changed without a local write");

	property p_read_five_six;
		@(posedge core_clk) disable iff (!rst_n)
		psel && !penable && !pwrite && paddr == GPC_ADDR_PINS_FIVE_SIX
		|=> prdata == {24'h000000, $past(pins_five_six_setup_q)};
	endproperty
	a_read_five_six: assert property (p_read_five_six)
		else $error("pin five/six setup read back wrong");

	property p_func_five;
		@(posedge core_clk) disable iff (!rst_n)
		pins_five_six_setup_q[1:0] == 2'h0
		|=> pad_oe[0] && pad_out[0] == $past(func_out[0]);
	endproperty
	a_func_five: assert property (p_func_five)
		else $error("pin five not in functional output");

	property p_tristate_five;
		@(posedge core_clk) disable iff (!rst_n)
		pins_five_six_setup_q[1:0] == 2'h2 |=> !pad_oe[0] && !pad_out[0];
	endproperty
	a_tristate_five: assert property (p_tristate_five)
		else $error("pin five driven while tri-stated");

	property p_gp_in_eight;
		@(posedge core_clk) disable iff (!rst_n)
		pins_seven_eight_setup_q[5:4] == 2'h3
		|=> !pad_oe[3] && gp_in_level[3] == $past(pad_sync_q[3]);
	endproperty
	a_gp_in_eight: assert property (p_gp_in_eight)
		else $error("pin eight input level not reported");

	property p_not_in_eight;
		@(posedge core_clk) disable iff (!rst_n)
		pins_seven_eight_setup_q[5:4] != 2'h3 |=> !gp_in_level[3];
	endproperty
	a_not_in_eight: assert property (p_not_in_eight)
		else $error("pin eight reports input level outside input mode");

	property p_gp_out_eight;
		@(posedge core_clk) disable iff (!rst_n)
		pins_seven_eight_setup_q[5:4] == 2'h1
		|=> pad_oe[3] && pad_out[3] == $past(pins_seven_eight_setup_q[7]);
	endproperty
	a_gp_out_eight: assert property (p_gp_out_eight)
		else $error("pin eight does not drive local level");

	property p_pass_colour;
		@(posedge core_clk) disable iff (!rst_n)
		colour_pass_through |=> colour_out == $past(colour_in);
	endproperty
	a_pass_colour: assert property (p_pass_colour)
		else $error("pass-through did not forward colour");

	property p_de_high;
		@(posedge core_clk) disable iff (!rst_n)
		!colour_pass_through && !data_enable_polarity && data_enable
		|=> colour_valid && colour_out == $past(colour_in);
	endproperty
	a_de_high: assert property (p_de_high)
		else $error("active-high data enable did not pass colour");

	property p_de_inv_idle;
		@(posedge core_clk) disable iff (!rst_n)
		!colour_pass_through && data_enable_polarity && data_enable
		|=> !colour_valid && colour_out == '0;
	endproperty
	a_de_inv_idle: assert property (p_de_inv_idle)
		else $error("idle inverted data enable passed colour");

	property p_normal_audio;
		@(posedge core_clk) disable iff (!rst_n)
		!colour_pass_through
		|=> protect_allowed && audio_packet_out == $past(audio_packet_in);
	endproperty
	a_normal_audio: assert property (p_normal_audio)
		else $error("audio or protection blocked outside pass-through");

	property p_not_gp_out_five;
		@(posedge core_clk) disable iff (!rst_n)
		pins_five_six_setup_q[1:0] == 2'h3 |=> !pad_oe[0] && !pad_out[0];
	endproperty
	a_not_gp_out_five: assert property (p_not_gp_out_five)
		else $error("pin five driven in input mode");

	c_pass: cover property (@(posedge core_clk) disable iff (!rst_n)
		colour_pass_through ##1 colour_valid);
	c_hold: cover property (@(posedge core_clk) disable iff (!rst_n)
		fc_load && hold_local_path_settings);
	c_err: cover property (@(posedge core_clk) disable iff (!rst_n)
		pready && pslverr);
	c_gp_in: cover property (@(posedge core_clk) disable iff (!rst_n)
		pins_seven_eight_setup_q[5:4] == 2'h3 && gp_in_level[3]);
	c_inv_de: cover property (@(posedge core_clk) disable iff (!rst_n)
		data_enable_polarity && !data_enable ##1 colour_valid);
endmodule : gpc_top
`default_nettype wire

// *** tb/gpc_fc_model.sv ***
// Forward-channel partner: the remote side pushing video path settings.
// Assumes core_clk domain; one load pulse for each cycle of send.
`timescale 1ns/1ns
`default_nettype none
module gpc_fc_model (
	input wire logic core_clk,
	input wire logic send,
	input wire logic [7:0] value,
	output logic fc_load,
	output logic [7:0] fc_path_value
);
	// Value is only meaningful with the pulse; it shows the inverse otherwise
	always @(posedge core_clk) begin
		fc_load <= send;
		fc_path_value <= send ? value : ~value;
	end
endmodule : gpc_fc_model
`default_nettype wire

// *** tb/gpio_pad_and_datapath_config_tb.sv ***
// Self-checking bench for the pin setup and video path register slice.
// Assumes a 25 MHz core_clk and the forward-channel model beside it.
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_and_datapath_config_tb import gpc_pkg::*;;
	logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, send = 1'b0, data_enable = 1'b0, audio = 1'b0;
	logic [GPC_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0] pstrb = 4'hF, func_out = '0, pad_in = '0;
	logic [3:0] pad_out, pad_oe, gp_in, lv;
	logic [7:0] fc_v = '0, fc_val, v, w;
	logic [23:0] col = '0, col_out;
	logic pready, pslverr, fc_load, cval, aout, prot, de;
	logic [32:0] exp_q[$];
	int mismatches = 0, comparisons = 0, cycles = 0, seed = 94802, i, m;
	always #20 core_clk = ~core_clk;
	gpc_top #(.COLOUR_W(24)) gpc_top_i (.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fc_load(fc_load), .fc_path_value(fc_val),
		.func_out(func_out), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .gp_in_level(gp_in), .data_enable(data_enable),
		.colour_in(col), .audio_packet_in(audio), .colour_out(col_out),
		.colour_valid(cval), .audio_packet_out(aout),
		.protect_allowed(prot));
	gpc_fc_model gpc_fc_model_i (.core_clk(core_clk), .send(send),
		.value(fc_v), .fc_load(fc_load), .fc_path_value(fc_val));
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic check(input string what, input logic [32:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Reads note their expected {pslverr, prdata} before the setup cycle
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s, input logic [32:0] x);
		@(posedge core_clk);
		if (!wr)
			exp_q.push_back(x);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d}, 4'hF, '0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		apb(1'b0, a, 32'h0, 4'hF, x);
	endtask : rd
	task automatic fc(input logic [7:0] val);
		fc_v <= val;
		send <= 1'b1;
		@(posedge core_clk);
		send <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : fc
	always @(posedge core_clk)
		if (psel && penable && pready && !pwrite)
			check("read", {pslverr, prdata}, exp_q.pop_front());
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(GPC_ADDR_PINS_FIVE_SIX, '0);
		rd(GPC_ADDR_PINS_SEVEN_EIGHT, '0);
		rd(GPC_ADDR_VIDEO_PATH, '0);
		#1;
		check("pad_oe", pad_oe, 4'hF);
		$display("reset test done");
		for (m = 0; m < 4; m++) begin
			@(posedge core_clk);
			v = $random(seed);
			func_out <= $random(seed);
			pad_in <= $random(seed);
			v = {v[7:6], m[1:0], v[3:2], m[1:0]};
			w = v ^ 8'h88;
			lv = {w[7], w[3], v[7], v[3]};
			wr(GPC_ADDR_PINS_FIVE_SIX, v);
			wr(GPC_ADDR_PINS_SEVEN_EIGHT, w);
			repeat (4) @(posedge core_clk);
			#1;
			check("pad_oe", pad_oe, m[1] ? 4'h0 : 4'hF);
			check("pad_out", pad_out, m == 0 ? func_out :
				m == 1 ? lv : 4'h0);
			check("gp_in", gp_in, m == 3 ? pad_in : 4'h0);
			rd(GPC_ADDR_PINS_FIVE_SIX, {25'h0, v});
			rd(GPC_ADDR_PINS_SEVEN_EIGHT, {25'h0, w});
		end
		$display("pin mode test done");
		wr(12'h08C, 8'hFF);
		rd(12'h08C, 33'h1_0000_0000);
		apb(1'b1, GPC_ADDR_VIDEO_PATH, 32'hFF, 4'hE, '0);
		rd(GPC_ADDR_VIDEO_PATH, '0);
		$display("refusal test done");
		fc(8'hE5);
		rd(GPC_ADDR_VIDEO_PATH, 33'h65);
		wr(GPC_ADDR_VIDEO_PATH, 8'h80);
		fc(8'h7F);
		rd(GPC_ADDR_VIDEO_PATH, 33'h80);
		$display("forward channel test done");
		for (m = 0; m < 4; m++) begin
			// Hold bit kept set; m[1] turns on colour pass-through and m[0] inverts the data enable
			wr(GPC_ADDR_VIDEO_PATH, {1'b1, m[1:0], 5'h0});
			for (i = 0; i < 8; i++) begin
				@(posedge core_clk);
				data_enable <= $random(seed);
				col <= $random(seed);
				audio <= $random(seed);
				@(posedge core_clk);
				#1;
				de = data_enable ^ m[0];
				check("colour_valid", cval, m[1] | de);
				check("colour", col_out, (m[1] | de) ? col : 24'h0);
				check("protect", prot, !m[1]);
				check("audio", aout, audio & !m[1]);
			end
		end
		$display("video path test done");
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		#1;
		check("pad_oe in reset", pad_oe, 4'h0);
		check("colour_valid in reset", cval, 1'b0);
		repeat (11) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(GPC_ADDR_PINS_FIVE_SIX, '0);
		rd(GPC_ADDR_PINS_SEVEN_EIGHT, '0);
		rd(GPC_ADDR_VIDEO_PATH, '0);
		#1;
		check("pad_oe after reset", pad_oe, 4'hF);
		$display("mid-run reset test done");
		end_of_test();
	end
endmodule : gpio_pad_and_datapath_config_tb
`default_nettype wire
